// ===== core/imc_mirror_crop.sv
`timescale 1ns/10ps
module imc_mirror_crop (
    // clock and reset
    input  wire logic                  CLK_SYS_I,
    input  wire logic                  RST_B_I,
    // acquisition state, from logic on this clock
    input  wire logic                  ACQ_RUN_I,
    // configuration write
    input  wire imc_pkg::imc_cfg_wr_t  CFG_WR_I,
    output logic                       CFG_ACK_O,
    output logic                       CFG_REJECT_O,
    output imc_pkg::imc_cfg_t          CFG_O,
    // pixel stream
    input  wire imc_pkg::imc_pix_in_t  PIX_IN_I,
    output imc_pkg::imc_pix_out_t      PIX_OUT_O
);
    import imc_pkg::*;

    // ------------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------------
    imc_cfg_t    cfg_ff, nxt_cfg, cand;
    logic        ack_ff, nxt_ack, rej_ff, nxt_rej;
    logic        cand_ok, accept;
    logic [17:0] x_end, y_end;
    logic [1:0]  cand_o;

    always_comb begin
        cand = cfg_ff;
        case (CFG_WR_I.sel)
            sel_orientation:  cand.image_orientation  = imc_orient_t'(CFG_WR_I.value[1:0]);
            sel_columns:      cand.full_frame_columns = CFG_WR_I.value;
            sel_rows:         cand.full_frame_rows    = CFG_WR_I.value;
            sel_start_column: cand.crop_start_column  = CFG_WR_I.value;
            sel_start_row:    cand.crop_start_row     = CFG_WR_I.value;
            sel_width:        cand.crop_width         = CFG_WR_I.value;
            sel_height:       cand.crop_height        = CFG_WR_I.value;
            default:          cand = cfg_ff;
        endcase
        cand_o  = cand.image_orientation;
        x_end   = {1'b0, cand.crop_start_column} + {1'b0, cand.crop_width};
        y_end   = {1'b0, cand.crop_start_row} + {1'b0, cand.crop_height};
        // whole candidate is checked so every held setting stays consistent
        cand_ok = (cand.full_frame_columns >= MIN_COLUMNS) && (cand.full_frame_columns <= MAX_COLUMNS)
               && (cand.full_frame_columns[COL_ALIGN_W-1:0] == '0)
               && (cand.full_frame_rows >= MIN_ROWS) && (cand.full_frame_rows <= MAX_ROWS)
               && (cand.crop_width >= MIN_WIDTH) && (cand.crop_height >= MIN_HEIGHT)
               && (cand.crop_start_column[COL_ALIGN_W-1:0] == '0)
               && (cand.crop_width[COL_ALIGN_W-1:0] == '0)
               && (x_end <= {1'b0, MAX_COLUMNS}) && (y_end <= {1'b0, MAX_ROWS})
               && (!cand_o[0] || (x_end <= {1'b0, cand.full_frame_columns}))
               && (!cand_o[1] || (y_end <= {1'b0, cand.full_frame_rows}));
        accept  = CFG_WR_I.valid && !ACQ_RUN_I && cand_ok;
        nxt_cfg = accept ? cand : cfg_ff;
        nxt_ack = accept;
        nxt_rej = CFG_WR_I.valid && !accept;
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            cfg_ff <= CFG_RESET;
            ack_ff <= 1'b0;
            rej_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            ack_ff <= nxt_ack;
            rej_ff <= nxt_rej;
        end
    end

    // ------------------------------------------------------------------
    // input position tracking and mapping
    // ------------------------------------------------------------------
    logic [16:0]  x_ff, nxt_x, y_ff, nxt_y, cur_x, cur_y, map_x, map_y;
    logic         bank_ff, nxt_bank, in_x, in_y, hflip, vflip;
    imc_pix_out_t out_ff, nxt_out;
    logic [1:0]   run_o;

    assign run_o = cfg_ff.image_orientation;
    assign hflip = run_o[0];
    assign vflip = run_o[1];

    // full column count always feeds the mapper, which only uses it while flipping horizontally
    imc_axis_map #(.W(COORD_W)) u_map_x (
        .coord_i  (cur_x),
        .mirror_i (hflip),
        .full_i   (cfg_ff.full_frame_columns),
        .start_i  (cfg_ff.crop_start_column),
        .size_i   (cfg_ff.crop_width),
        .out_o    (map_x),
        .inside_o (in_x)
    );

    imc_axis_map #(.W(COORD_W)) u_map_y (
        .coord_i  (cur_y),
        .mirror_i (vflip),
        .full_i   (cfg_ff.full_frame_rows),
        .start_i  (cfg_ff.crop_start_row),
        .size_i   (cfg_ff.crop_height),
        .out_o    (map_y),
        .inside_o (in_y)
    );

    always_comb begin
        cur_x = PIX_IN_I.sof ? '0 : x_ff;
        cur_y = PIX_IN_I.sof ? '0 : y_ff;
        nxt_x = x_ff;
        nxt_y = y_ff;
        // counters saturate; the camera never exceeds the maximum frame
        if (PIX_IN_I.valid) begin
            // hold at the limit so an overlong line cannot wrap back into the window
            nxt_x = (cur_x == MAX_COLUMNS) ? cur_x : cur_x + 17'h0_0001;
            if (PIX_IN_I.eol) begin
                nxt_x = '0;
            end
            nxt_y = cur_y;
            if (PIX_IN_I.eol && (cur_y != MAX_ROWS)) begin
                nxt_y = cur_y + 17'h0_0001;
            end
        end
        // alternate memory bank per frame while flipping vertically so a read never meets the write
        nxt_bank = (PIX_IN_I.valid && PIX_IN_I.sof && vflip) ? ~bank_ff : bank_ff;
        nxt_out.valid       = PIX_IN_I.valid && in_x && in_y;
        nxt_out.frame_start = PIX_IN_I.valid && PIX_IN_I.sof;
        nxt_out.bank        = nxt_bank;
        nxt_out.col         = map_x;
        nxt_out.row         = map_y;
        nxt_out.data        = PIX_IN_I.data;
    end

    // missing pixels of short frames are simply never written downstream
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            x_ff    <= '0;
            y_ff    <= '0;
            bank_ff <= 1'b0;
            out_ff  <= '0;
        end else begin
            x_ff    <= nxt_x;
            y_ff    <= nxt_y;
            bank_ff <= nxt_bank;
            out_ff  <= nxt_out;
        end
    end

    assign CFG_O        = cfg_ff;
    assign CFG_ACK_O    = ack_ff;
    assign CFG_REJECT_O = rej_ff;
    assign PIX_OUT_O    = out_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic        pv_ff;
    logic [16:0] pcol_ff, prow_ff;

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I || out_ff.frame_start) begin
            pv_ff   <= 1'b0;
            pcol_ff <= '0;
            prow_ff <= '0;
        end else if (out_ff.valid) begin
            pv_ff   <= 1'b1;
            pcol_ff <= out_ff.col;
            prow_ff <= out_ff.row;
        end
    end

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_B_I);

    a_reset_orient: assert property ($rose(RST_B_I) |-> cfg_ff.image_orientation == orient_unmirrored)
        else $error("orientation not unmirrored after reset");
    a_run_blocks_write: assert property (CFG_WR_I.valid && ACQ_RUN_I |=> $stable(cfg_ff) && rej_ff && !ack_ff)
        else $error("config changed while running");
    a_hflip_bound: assert property (hflip |-> ({1'b0, cfg_ff.crop_start_column} + {1'b0, cfg_ff.crop_width})
                                              <= {1'b0, cfg_ff.full_frame_columns})
        else $error("horizontal window exceeds full columns");
    a_vflip_bound: assert property (vflip |-> ({1'b0, cfg_ff.crop_start_row} + {1'b0, cfg_ff.crop_height})
                                              <= {1'b0, cfg_ff.full_frame_rows})
        else $error("vertical window exceeds full rows");
    a_col_align: assert property (cfg_ff.crop_start_column[1:0] == 2'h0 && cfg_ff.crop_width[1:0] == 2'h0
                                  && cfg_ff.full_frame_columns[1:0] == 2'h0)
        else $error("column setting not a multiple of four");
    a_max_dims: assert property (({1'b0, cfg_ff.crop_start_column} + {1'b0, cfg_ff.crop_width}) <= 18'h0_c000
                                 && ({1'b0, cfg_ff.crop_start_row} + {1'b0, cfg_ff.crop_height}) <= 18'h1_0000)
        else $error("window exceeds maximum frame");
    a_dim_ranges: assert property (cfg_ff.full_frame_columns >= 17'h0_0008 && cfg_ff.full_frame_columns <= 17'h0_c000
                                   && cfg_ff.full_frame_rows >= 17'h0_0002)
        else $error("full frame size out of range");
    a_out_window: assert property (out_ff.valid |-> out_ff.col < cfg_ff.crop_width
                                   && out_ff.row < cfg_ff.crop_height)
        else $error("output outside region");
    a_bank_toggle: assert property (PIX_IN_I.valid && PIX_IN_I.sof && vflip |=> bank_ff != $past(bank_ff))
        else $error("bank did not alternate");
    a_line_order: assert property (out_ff.valid && pv_ff && out_ff.row == prow_ff
                                   |-> out_ff.col == (hflip ? pcol_ff - 17'h0_0001 : pcol_ff + 17'h0_0001))
        else $error("pixel order within line wrong");

    c_hflip_out: cover property (hflip && out_ff.valid);
    c_vflip_out: cover property (vflip && out_ff.valid && out_ff.row == 17'h0_0000);
    c_both_out:  cover property (hflip && vflip && out_ff.valid);
    c_rejected:  cover property (rej_ff && !ACQ_RUN_I);

endmodule : imc_mirror_crop

// ===== core/imc_pkg.sv
package imc_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int COORD_W       = 17;
    localparam int PIX_W         = 8;
    localparam int COL_ALIGN_W   = 2;

    // ------------------------------------------------------------------
    // dimension limits and reset values
    // ------------------------------------------------------------------
    localparam logic [16:0] MAX_COLUMNS  = 17'h0_c000;
    localparam logic [16:0] MIN_COLUMNS  = 17'h0_0008;
    localparam logic [16:0] MAX_ROWS     = 17'h1_0000;
    localparam logic [16:0] MIN_ROWS     = 17'h0_0002;
    localparam logic [16:0] MIN_WIDTH    = 17'h0_0008;
    localparam logic [16:0] MIN_HEIGHT   = 17'h0_0002;
    localparam logic [16:0] DEF_COLUMNS  = 17'h0_0400;
    localparam logic [16:0] DEF_ROWS     = 17'h0_0400;
    localparam logic [16:0] DEF_WIDTH    = 17'h0_0400;
    localparam logic [16:0] DEF_HEIGHT   = 17'h0_0400;
    localparam logic [16:0] DEF_START    = 17'h0_0000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    // bit 0 selects horizontal flip, bit 1 vertical flip
    typedef enum logic [1:0] {
        orient_unmirrored,
        orient_flip_horizontal,
        orient_flip_vertical,
        orient_flip_both
    } imc_orient_t;

    typedef enum logic [2:0] {
        sel_orientation,
        sel_columns,
        sel_rows,
        sel_start_column,
        sel_start_row,
        sel_width,
        sel_height
    } imc_sel_t;

    typedef struct packed {
        logic        valid;
        imc_sel_t    sel;
        logic [16:0] value;
    } imc_cfg_wr_t;

    typedef struct packed {
        imc_orient_t image_orientation;
        logic [16:0] full_frame_columns;
        logic [16:0] full_frame_rows;
        logic [16:0] crop_start_column;
        logic [16:0] crop_start_row;
        logic [16:0] crop_width;
        logic [16:0] crop_height;
    } imc_cfg_t;

    typedef struct packed {
        logic             valid;
        logic             sof;
        logic             eol;
        logic [PIX_W-1:0] data;
    } imc_pix_in_t;

    typedef struct packed {
        logic             valid;
        logic             frame_start;
        logic             bank;
        logic [16:0]      col;
        logic [16:0]      row;
        logic [PIX_W-1:0] data;
    } imc_pix_out_t;

    localparam imc_cfg_t CFG_RESET = '{
        image_orientation:  orient_unmirrored,
        full_frame_columns: DEF_COLUMNS,
        full_frame_rows:    DEF_ROWS,
        crop_start_column:  DEF_START,
        crop_start_row:     DEF_START,
        crop_width:         DEF_WIDTH,
        crop_height:        DEF_HEIGHT
    };

endpackage : imc_pkg

// ===== core/imc_axis_map.sv
`timescale 1ns/10ps
module imc_axis_map #(
    parameter int W = 17
) (
    // position and window
    input  wire logic [W-1:0] coord_i,
    input  wire logic         mirror_i,
    input  wire logic [W-1:0] full_i,
    input  wire logic [W-1:0] start_i,
    input  wire logic [W-1:0] size_i,
    // result
    output logic      [W-1:0] out_o,
    output logic              inside_o
);

    logic [W:0] win_end;
    logic [W:0] limit;
    logic [W:0] mapped;
    logic [W:0] offset;

    // unmirrored axis ends at start+size, the full count is not consulted
    assign win_end  = {1'b0, start_i} + {1'b0, size_i};
    assign limit    = mirror_i ? {1'b0, full_i} : win_end;
    // mirror over the full count first, crop on the mirrored position
    assign mapped   = mirror_i ? ({1'b0, full_i} - {{W{1'b0}}, 1'b1} - {1'b0, coord_i}) : {1'b0, coord_i};
    assign offset   = mapped - {1'b0, start_i};
    assign inside_o = ({1'b0, coord_i} < limit) && (mapped >= {1'b0, start_i}) && (mapped < win_end);
    assign out_o    = offset[W-1:0];

endmodule : imc_axis_map

// ===== test/imc_cam_model.sv
`timescale 1ns/10ps
module imc_cam_model (
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_b_i,
    // frame request and size
    input  wire logic            go_i,
    input  wire logic [16:0]     cols_i,
    input  wire logic [16:0]     rows_i,
    // pixel link
    output imc_pkg::imc_pix_in_t pix_o,
    output logic                 idle_o
);
    import imc_pkg::*;
    logic        busy_ff;
    logic [16:0] x_ff;
    logic [16:0] y_ff;
    // ------------------------------------------------------------------
    // frame generator
    // ------------------------------------------------------------------
    // pixel value encodes its own position so any remap shows in the data
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            busy_ff <= 1'b0;
            x_ff    <= '0;
            y_ff    <= '0;
            pix_o   <= '0;
        end else if (!busy_ff) begin
            // idle link: data keeps toggling so stale values never look valid
            pix_o.valid <= 1'b0;
            pix_o.data  <= ~pix_o.data;
            busy_ff     <= go_i;
            x_ff        <= '0;
            y_ff        <= '0;
        end else begin
            pix_o.valid <= 1'b1;
            pix_o.sof   <= (x_ff == '0) && (y_ff == '0);
            pix_o.eol   <= (x_ff == cols_i - 17'h0_0001);
            pix_o.data  <= PIX_W'({y_ff[3:0], x_ff[3:0]});
            if (x_ff == cols_i - 17'h0_0001) begin
                x_ff    <= '0;
                y_ff    <= y_ff + 17'h0_0001;
                busy_ff <= (y_ff != rows_i - 17'h0_0001);
            end else begin
                x_ff <= x_ff + 17'h0_0001;
            end
        end
    end
    assign idle_o = !busy_ff;
endmodule : imc_cam_model

// ===== test/test_imc_mirror_crop.sv
`timescale 1ns/10ps
module test_imc_mirror_crop;
    import imc_pkg::*;
    localparam int CW = $bits(imc_cfg_t);
    logic         clk_sys;
    logic         rst_b;
    logic         acq_run;
    logic         go;
    logic         cam_idle;
    logic         exp_bank;
    logic         cfg_ack;
    logic         cfg_reject;
    imc_cfg_wr_t  cfg_wr;
    imc_cfg_t     cfg_out;
    imc_cfg_t     exp_cfg;
    imc_pix_in_t  pix_in;
    imc_pix_out_t pix_out;
    logic [16:0]  xm, ym, xo, yo;
    logic [1:0]   ori;
    int           err_total, comparisons, n_pix, n_fs;

    imc_mirror_crop DUT (.CLK_SYS_I(clk_sys), .RST_B_I(rst_b), .ACQ_RUN_I(acq_run), .CFG_WR_I(cfg_wr),
        .CFG_ACK_O(cfg_ack), .CFG_REJECT_O(cfg_reject), .CFG_O(cfg_out), .PIX_IN_I(pix_in), .PIX_OUT_O(pix_out));
    // camera height equals the programmed row count, as vertical flip needs
    imc_cam_model cam (.clk_i(clk_sys), .rst_b_i(rst_b), .go_i(go), .cols_i(17'h0_0010),
        .rows_i(17'h0_0004), .pix_o(pix_in), .idle_o(cam_idle));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [CW-1:0] seen, input logic [CW-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic conclude;
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic cfg(input imc_sel_t sel, input logic [16:0] val, input logic ok);
        @(posedge clk_sys);
        cfg_wr <= '{valid: 1'b1, sel: sel, value: val};
        @(posedge clk_sys);
        cfg_wr.valid <= 1'b0;
        if (ok) begin
            case (sel)
                sel_orientation:  exp_cfg.image_orientation = imc_orient_t'(val[1:0]);
                sel_columns:      exp_cfg.full_frame_columns = val;
                sel_rows:         exp_cfg.full_frame_rows = val;
                sel_start_column: exp_cfg.crop_start_column = val;
                sel_start_row:    exp_cfg.crop_start_row = val;
                sel_width:        exp_cfg.crop_width = val;
                default:          exp_cfg.crop_height = val;
            endcase
        end
        #1;
        chk("accept", CW'(cfg_ack), CW'(ok));
        chk("refuse", CW'(cfg_reject), CW'(!ok));
        chk("settings", cfg_out, exp_cfg);
    endtask : cfg

    task automatic frame(input string name);
        int i;
        n_pix = 0;
        n_fs = 0;
        @(posedge clk_sys);
        go      <= 1'b1;
        acq_run <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        // camera shows busy only after the edge that takes go
        @(negedge clk_sys);
        for (i = 0; i < 400 && cam_idle !== 1'b1; i++) @(negedge clk_sys);
        if (i == 400) begin
            err_total++;
            conclude();
        end
        repeat (3) @(negedge clk_sys);
        @(posedge clk_sys);
        acq_run <= 1'b0;
        chk("pixel count", CW'(n_pix), CW'(exp_cfg.crop_width * exp_cfg.crop_height));
        chk("frame starts", CW'(n_fs), CW'(1));
        $display("test %s done", name);
    endtask : frame
    // ------------------------------------------------------------------
    // output monitor
    // ------------------------------------------------------------------
    // undo crop, then undo mirror, to recover the camera position
    always @(negedge clk_sys) begin
        // a vertical-flip frame moves to the other buffer from its first pixel on
        if (rst_b === 1'b1 && pix_out.frame_start === 1'b1 && (exp_cfg.image_orientation == orient_flip_vertical
                                                             || exp_cfg.image_orientation == orient_flip_both)) begin
            exp_bank = ~exp_bank;
        end
        if (rst_b === 1'b1 && pix_out.valid === 1'b1) begin
            ori = exp_cfg.image_orientation;
            xm  = pix_out.col + exp_cfg.crop_start_column;
            ym  = pix_out.row + exp_cfg.crop_start_row;
            xo  = ori[0] ? exp_cfg.full_frame_columns - 17'h0_0001 - xm : xm;
            yo  = ori[1] ? exp_cfg.full_frame_rows - 17'h0_0001 - ym : ym;
            chk("pixel data", CW'(pix_out.data), CW'({yo[3:0], xo[3:0]}));
            chk("in window", CW'(pix_out.col < exp_cfg.crop_width && pix_out.row < exp_cfg.crop_height), CW'(1));
            chk("bank", CW'(pix_out.bank), CW'(exp_bank));
            n_pix++;
        end
        if (rst_b === 1'b1 && pix_out.frame_start === 1'b1) n_fs++;
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b       = 1'b0;
        acq_run     = 1'b0;
        go          = 1'b0;
        cfg_wr      = '0;
        exp_cfg     = CFG_RESET;
        exp_bank    = 1'b0;
        err_total   = 0;
        comparisons = 0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        chk("reset settings", cfg_out, exp_cfg);
        cfg(sel_columns, 17'h0_0004, 1'b0);
        cfg(sel_columns, 17'h0_c004, 1'b0);
        cfg(sel_columns, 17'h0_0012, 1'b0);
        cfg(sel_rows, 17'h0_0001, 1'b0);
        cfg(sel_rows, 17'h1_0000, 1'b1);
        cfg(sel_start_column, 17'h0_bffc, 1'b0);
        cfg(sel_start_row, 17'h0_fc01, 1'b0);
        cfg(sel_start_row, 17'h0_fc00, 1'b1);
        cfg(sel_width, 17'h0_0006, 1'b0);
        cfg(sel_start_column, 17'h0_0002, 1'b0);
        $display("test limits done");
        // full columns below width is fine while unmirrored
        cfg(sel_columns, 17'h0_0010, 1'b1);
        cfg(sel_rows, 17'h0_0004, 1'b1);
        cfg(sel_width, 17'h0_0008, 1'b1);
        cfg(sel_height, 17'h0_0002, 1'b1);
        cfg(sel_start_column, 17'h0_0004, 1'b1);
        cfg(sel_start_row, 17'h0_0001, 1'b1);
        @(posedge clk_sys);
        acq_run <= 1'b1;
        cfg(sel_width, 17'h0_000c, 1'b0);
        cfg(sel_orientation, 17'h0_0002, 1'b0);
        @(posedge clk_sys);
        acq_run <= 1'b0;
        $display("test setup done");
        for (int o = 0; o < 4; o++) begin
            cfg(sel_orientation, 17'(o), 1'b1);
            if (o[0]) cfg(sel_start_column, 17'h0_000c, 1'b0);
            if (o[1]) cfg(sel_start_row, 17'h0_0003, 1'b0);
            frame($sformatf("orientation %0d", o));
        end
        conclude();
    end
endmodule : test_imc_mirror_crop
